// [hw/boot_intake_pkg.sv]
package boot_intake_pkg;

    // Mode clock divider
    localparam int unsigned BOOT_CLK_DIV = 256;
    // Stream length and word packing
    localparam int unsigned STREAM_BITS = 256;
    localparam int unsigned CFG_WORD_W = 8;
    localparam int unsigned CFG_FIFO_DEPTH = 32;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_OFF     = 4'h1,
        ST_CAPTURE = 4'h2,
        ST_HOLD    = 4'h4,
        ST_RUN     = 4'h8
    } seq_state_t;

    // Synchroniser lanes
    localparam int unsigned SYNC_SUPPLY = 0;
    localparam int unsigned SYNC_COLD = 1;
    localparam int unsigned SYNC_REINIT = 2;
    localparam int unsigned SYNC_DIN = 3;
    localparam logic [3:0] SYNC_RESET = 4'h0;

endpackage

// [hw/cfg_word_fifo.sv]
module cfg_word_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count
    assign in_ready = (cnt_q != CW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage, no reset needed on the data itself
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// [hw/reset_and_boot_mode_intake.sv]
module reset_and_boot_mode_intake #(
    parameter int unsigned DIV_RATIO = boot_intake_pkg::BOOT_CLK_DIV,
    parameter int unsigned N_BITS = boot_intake_pkg::STREAM_BITS,
    parameter int unsigned WORD_W = boot_intake_pkg::CFG_WORD_W,
    parameter int unsigned FIFO_DEPTH = boot_intake_pkg::CFG_FIFO_DEPTH
) (
    // Primary clock and power-on reset
    input wire logic clk,
    input wire logic rst_n,
    // Board reset pins
    input wire logic supply_good,
    input wire logic cold_init_n,
    input wire logic reinit_n,
    // Serial configuration pins
    output logic boot_cfg_clk,
    input wire logic boot_cfg_din,
    // Reset towards the core
    output logic core_rst_n,
    output logic warm_reset,
    output logic cfg_done,
    // Captured configuration words
    output logic [WORD_W-1:0] cfg_data,
    output logic cfg_valid,
    input wire logic cfg_ready
);
    import boot_intake_pkg::*;

    localparam int unsigned DIV_W = $clog2(DIV_RATIO);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);
    localparam logic [DIV_W-1:0] DIV_RISE = DIV_W'(DIV_RATIO / 2 - 1);
    localparam int unsigned BC_W = $clog2(N_BITS + 1);
    localparam logic [BC_W-1:0] BITS_ALL = BC_W'(N_BITS);
    localparam int unsigned WB_W = $clog2(WORD_W + 1);
    localparam logic [WB_W-1:0] WORD_BITS = WB_W'(WORD_W);

    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic supply_prev_q;
    logic supply_s;
    logic cold_s;
    logic reinit_s;
    logic din_s;
    logic supply_rise;
    logic [DIV_W-1:0] div_q;
    logic rise_tick;
    logic fall_tick;
    logic clk_run;
    logic sample_now;
    logic boot_cfg_clk_q;
    logic [WORD_W-1:0] shreg_q;
    logic [WB_W-1:0] wbits_q;
    logic [BC_W-1:0] bit_cnt_q;
    logic [WORD_W-1:0] word_q;
    logic pend_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic flush;
    logic stream_in;
    seq_state_t state_q;
    seq_state_t state_d;
    logic core_rst_n_q;
    logic warm_reset_q;
    logic cfg_done_q;
    logic [WORD_W-1:0] cfg_data_q;
    logic cfg_valid_q;

    // Every pin passes two flops; only the second stage is read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
        end else begin
            sync1_q <= {boot_cfg_din, reinit_n, cold_init_n, supply_good};
            sync2_q <= sync1_q;
        end
    end

    assign supply_s = sync2_q[SYNC_SUPPLY];
    assign cold_s = sync2_q[SYNC_COLD];
    assign reinit_s = sync2_q[SYNC_REINIT];
    assign din_s = sync2_q[SYNC_DIN];

    // Edge detect on the settled supply indication
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_prev_q <= 1'b0;
        end else begin
            supply_prev_q <= supply_s;
        end
    end

    assign supply_rise = supply_s && !supply_prev_q;

    // Free-running divide by DIV_RATIO, never held or reloaded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
        end
    end

    assign rise_tick = (div_q == DIV_RISE);
    assign fall_tick = (div_q == DIV_LAST);
    // High pulses are skipped while a word waits for FIFO room, so the source stalls
    assign clk_run = (state_q == ST_CAPTURE) && !pend_q && (bit_cnt_q != BITS_ALL);
    assign sample_now = rise_tick && clk_run;

    // Mode clock output: half high, half low, low when gated or unpowered
    // A high phase is cut on supply loss, so no late fall can advance the source past bit 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cfg_clk_q <= 1'b0;
        end else if (flush) begin
            boot_cfg_clk_q <= 1'b0;
        end else if (fall_tick) begin
            boot_cfg_clk_q <= 1'b0;
        end else if (sample_now) begin
            boot_cfg_clk_q <= 1'b1;
        end
    end

    // Serial shift, first bit ends up in the word MSB
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_q <= '0;
            wbits_q <= '0;
            bit_cnt_q <= '0;
        end else if (supply_rise || !supply_s) begin
            shreg_q <= '0;
            wbits_q <= '0;
            bit_cnt_q <= '0;
        end else if (sample_now) begin
            shreg_q <= {shreg_q[WORD_W-2:0], din_s};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            wbits_q <= (wbits_q == WORD_BITS - 1'b1) ? '0 : wbits_q + 1'b1;
        end
    end

    // Completed word waits here until the FIFO accepts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= '0;
            pend_q <= 1'b0;
        end else if (supply_rise || !supply_s) begin
            pend_q <= 1'b0;
        end else if (sample_now && (wbits_q == WORD_BITS - 1'b1)) begin
            word_q <= {shreg_q[WORD_W-2:0], din_s};
            pend_q <= 1'b1;
        end else if (pend_q && fifo_in_ready) begin
            pend_q <= 1'b0;
        end
    end

    // A fresh supply drops any words of an older stream
    assign flush = supply_rise || !supply_s;
    assign fifo_out_ready = !cfg_valid_q || cfg_ready;

    cfg_word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(flush),
        .in_valid(pend_q),
        .in_ready(fifo_in_ready),
        .in_data(word_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Registered output stage in front of the consumer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_data_q <= '0;
            cfg_valid_q <= 1'b0;
        end else if (flush) begin
            cfg_valid_q <= 1'b0;
        end else if (fifo_out_ready) begin
            cfg_valid_q <= fifo_out_valid;
            if (fifo_out_valid) begin
                cfg_data_q <= fifo_out_data;
            end
        end
    end

    assign stream_in = (bit_cnt_q == BITS_ALL) && !pend_q;

    // Sequencer; losing supply wins over everything else
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (supply_rise) begin
                    state_d = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                if (stream_in) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Releases are trusted to be clean, only the synced level is used
                if (cold_s && reinit_s) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!cold_s || !reinit_s) begin
                    state_d = ST_HOLD;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!supply_s) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Core reset and status flags, all registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_rst_n_q <= 1'b0;
            warm_reset_q <= 1'b0;
            cfg_done_q <= 1'b0;
        end else begin
            core_rst_n_q <= (state_d == ST_RUN);
            cfg_done_q <= (state_d == ST_HOLD) || (state_d == ST_RUN);
            if (state_d == ST_OFF || (state_q == ST_RUN && !cold_s)) begin
                warm_reset_q <= 1'b0;
            end else if (state_q == ST_RUN && cold_s && !reinit_s) begin
                warm_reset_q <= 1'b1;
            end
        end
    end

    assign boot_cfg_clk = boot_cfg_clk_q;
    assign core_rst_n = core_rst_n_q;
    assign warm_reset = warm_reset_q;
    assign cfg_done = cfg_done_q;
    assign cfg_data = cfg_data_q;
    assign cfg_valid = cfg_valid_q;
endmodule

// [verification/boot_intake_sva.sv]
module boot_intake_sva #(
    parameter int unsigned DIV_RATIO = 256,
    parameter int unsigned WORD_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Board pins
    input wire logic supply_good,
    input wire logic cold_init_n,
    input wire logic reinit_n,
    input wire logic boot_cfg_clk,
    // Core side
    input wire logic core_rst_n,
    input wire logic warm_reset,
    input wire logic cfg_done,
    input wire logic [WORD_W-1:0] cfg_data,
    input wire logic cfg_valid,
    input wire logic cfg_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // First rise may wait a whole divider lap plus the pin synchroniser
    localparam int START_MAX = DIV_RATIO + 6;
    logic [15:0] hi_cnt_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Cycles spent high in the current mode clock phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt_q <= 16'h0;
        end else begin
            hi_cnt_q <= boot_cfg_clk ? hi_cnt_q + 16'h1 : 16'h0;
        end
    end
    // Supply steady long enough that a drop cannot cut a phase short
    sequence sup_steady_s;
        supply_good && $past(supply_good) && $past(supply_good, 2) && $past(supply_good, 3);
    endsequence
    sequence sup_rise_s;
        $rose(supply_good) ##1 supply_good [*3];
    endsequence
    chk_clk_high_len: assert property (sup_steady_s ##0 $fell(boot_cfg_clk) |-> hi_cnt_q == 16'(DIV_RATIO / 2))
        else $error("mode clock high phase has wrong length");
    chk_capture_start: assert property (sup_rise_s |-> ##[1:START_MAX] $rose(boot_cfg_clk))
        else $error("mode clock did not start after supply good");
    chk_core_held: assert property (core_rst_n |-> cfg_done && $past(cold_init_n, 3) && $past(reinit_n, 3))
        else $error("core released before stream captured or reset pins released");
    chk_supply_drop: assert property ($fell(supply_good) |-> ##[2:5] (!cfg_done && !cfg_valid && !core_rst_n))
        else $error("supply loss did not return to off");
    chk_clk_idle_off: assert property (!supply_good [*5] |-> !boot_cfg_clk)
        else $error("mode clock runs without supply");
    chk_warm_entry: assert property ($fell(reinit_n) && cold_init_n && core_rst_n |-> ##[2:5] (!core_rst_n && warm_reset))
        else $error("warm reset not taken");
    chk_cold_entry: assert property ($fell(cold_init_n) && cfg_done |-> ##[2:5] (!core_rst_n && !warm_reset && cfg_done))
        else $error("cold reset taken as warm");
    chk_word_holds: assert property (sup_steady_s ##0 (cfg_valid && !cfg_ready) |=> cfg_valid && $stable(cfg_data))
        else $error("word changed before it was taken");
endmodule

bind reset_and_boot_mode_intake boot_intake_sva #(.DIV_RATIO(DIV_RATIO), .WORD_W(WORD_W)) sva (
    .clk(clk), .rst_n(rst_n), .supply_good(supply_good), .cold_init_n(cold_init_n), .reinit_n(reinit_n),
    .boot_cfg_clk(boot_cfg_clk), .core_rst_n(core_rst_n), .warm_reset(warm_reset), .cfg_done(cfg_done),
    .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready));

// [verification/cfg_stream_source.sv]
module cfg_stream_source #(
    parameter int unsigned N = 48
) (
    // Clock and power
    input wire logic clk,
    input wire logic supply_good,
    // Stream
    input wire logic [N-1:0] pattern,
    input wire logic boot_cfg_clk,
    output logic boot_cfg_din
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx = 0;
    logic clk_prev = 1'b0;
    // Next bit only after the mode clock has fallen
    always @(posedge clk) begin
        clk_prev <= boot_cfg_clk;
        if (!supply_good) begin
            idx <= 0;
        end else if (clk_prev && !boot_cfg_clk) begin
            idx <= idx + 1;
        end
    end
    // Past the end the line toggles, so a stale bit is never read as valid
    assign boot_cfg_din = (idx < N) ? pattern[N-1-idx] : idx[0];
endmodule

// [verification/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DIV = 16;
    localparam int unsigned NB = 48;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_good = 1'b0;
    logic cold_init_n = 1'b0;
    logic reinit_n = 1'b0;
    logic cfg_ready = 1'b0;
    logic boot_cfg_clk, boot_cfg_din, core_rst_n, warm_reset, cfg_done, cfg_valid;
    logic [7:0] cfg_data;
    logic [NB-1:0] pattern = '0;
    logic [15:0] lfsr_q = 16'h0051;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int exp_q[$];
    always #5 clk = ~clk;
    // Small divider and a two word buffer so stalls come quickly
    reset_and_boot_mode_intake #(.DIV_RATIO(DIV), .N_BITS(NB), .WORD_W(8), .FIFO_DEPTH(2)) dut (
        .clk(clk), .rst_n(rst_n), .supply_good(supply_good), .cold_init_n(cold_init_n), .reinit_n(reinit_n),
        .boot_cfg_clk(boot_cfg_clk), .boot_cfg_din(boot_cfg_din), .core_rst_n(core_rst_n),
        .warm_reset(warm_reset), .cfg_done(cfg_done), .cfg_data(cfg_data), .cfg_valid(cfg_valid),
        .cfg_ready(cfg_ready));
    cfg_stream_source #(.N(NB)) src (.clk(clk), .supply_good(supply_good), .pattern(pattern),
        .boot_cfg_clk(boot_cfg_clk), .boot_cfg_din(boot_cfg_din));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run of a few thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            conclude();
        end
    end
    // Pins change only at the falling edge; status is {done, core out of reset, warm}
    task automatic step(input string name, input logic s, c, r, input int n, input logic [2:0] exp);
        supply_good = s;
        cold_init_n = c;
        reinit_n = r;
        repeat (n) @(negedge clk);
        check(name, {5'h0, cfg_done, core_rst_n, warm_reset}, {5'h0, exp});
        $display("test %s done", name);
    endtask
    // New random stream; expected words first bit in the top place
    task automatic load();
        exp_q.delete();
        for (int i = 0; i < NB; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            pattern[i] = lfsr_q[0];
        end
        for (int w = 0; w < NB / 8; w++) begin
            exp_q.push_back(int'(pattern[NB-1-8*w -: 8]));
        end
    endtask
    // Random consumer stalls; a word seen at the falling edge is taken at the next rise
    task automatic drain();
        int guard;
        guard = 0;
        while (exp_q.size() > 0 && guard < 4000) begin
            @(negedge clk);
            guard++;
            lfsr_q = lfsr_next(lfsr_q);
            cfg_ready = (cfg_valid === 1'b1) & lfsr_q[0];
            if (cfg_ready === 1'b1) begin
                check("cfg_data", cfg_data, 8'(exp_q.pop_front()));
            end
        end
        @(negedge clk);
        cfg_ready = 1'b0;
        check("words_left", 8'(exp_q.size()), 8'h00);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        step("no_supply", 1'b0, 1'b1, 1'b1, 30, 3'h0);
        load();
        step("stalled", 1'b1, 1'b0, 1'b0, NB * DIV + 200, 3'h0);
        drain();
        step("cold_run", 1'b1, 1'b1, 1'b1, 8, 3'h6);
        step("warm_in", 1'b1, 1'b1, 1'b0, 6, 3'h5);
        step("warm_out", 1'b1, 1'b1, 1'b1, 6, 3'h7);
        step("cold_in", 1'b1, 1'b0, 1'b0, 6, 3'h4);
        step("cold_out", 1'b1, 1'b1, 1'b1, 6, 3'h6);
        step("supply_off", 1'b0, 1'b1, 1'b1, 6, 3'h0);
        load();
        step("part_capture", 1'b1, 1'b1, 1'b1, 100, 3'h0);
        step("abort", 1'b0, 1'b1, 1'b1, 6, 3'h0);
        supply_good = 1'b1;
        drain();
        step("restart_run", 1'b1, 1'b1, 1'b1, 8, 3'h6);
        conclude();
    end
endmodule
